// ### sleep_wakeup_timer.sv
// Sleep wake-up timer: 31-bit slow counter, Event 0 compare, wake, DMA
// trigger and CPU interrupt flag, reached over the SFR port.
// Assumes all inputs are synchronous to i_ref_clk and the 32 kHz crystal
// level is sampled here at the reference rate.
`timescale 1ns/1ps
module sleep_wakeup_timer
  import sleep_timer_pkg::*;
(
  // Clock and reset
  input  wire logic        i_ref_clk,
  input  wire logic        i_reset_n,
  // Special-function register port
  input  wire sfr_req_t    i_sfr,
  output logic             o_sfr_hit,
  output logic [7:0]       o_sfr_rdata,
  // Clock sources
  input  wire logic        i_xtal_32k,
  input  wire logic        i_use_xtal,
  input  wire logic        i_hs_xosc_on,
  // Power state
  input  wire logic        i_in_power_mode,
  input  wire power_mode_t i_power_mode,
  // CPU interrupt side
  input  wire logic        i_sleep_irq_enable,
  input  wire logic        i_cpu_irq_flag_clr,
  output logic             o_cpu_sleep_irq_flag,
  output logic             o_sleep_irq_request,
  // Event outputs
  output logic             o_wake_request,
  output logic             o_wake_dma_trigger
);

  ////////////////////////////////////////////////////////////////////////////
  // State

  typedef struct packed
  {
    logic [30:0] count;
    logic        xtal_prev;
    logic        restart;
    logic [15:0] wake_cmp;
    logic [2:0]  ctrl_rsvd;
    logic [1:0]  res;
    logic        irq_rsvd_high;
    logic        irq_rsvd_low;
    logic        ev_flag;
    logic        ev_mask;
    logic        cpu_flag;
    logic        dma;
    logic        wake;
    logic [7:0]  rdata;
  } timer_state_t;

  timer_state_t st;
  timer_state_t next_st;

  logic        rc_tick;
  logic        calibrate;
  logic        sleep_tick;
  logic        running;
  logic        low_power_wake;
  logic        clear_wr;
  logic        cmp_hit;
  logic [30:0] count_step;
  logic [15:0] view_now;

  function automatic logic [15:0] view_slice(input logic [30:0] c,
                                             input logic [1:0]  r);
    logic [30:0] sh;
    sh = c >> (RES_STEP * int'(r));
    return sh[15:0];
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Clock source and run conditions

  // Calibrate only while the fast crystal runs in active or power mode zero
  assign calibrate = i_hs_xosc_on &&
                     (!i_in_power_mode || i_power_mode == PM_ZERO);

  rc_tick_divider u_rc_div
  (
    .i_ref_clk   (i_ref_clk),
    .i_reset_n   (i_reset_n),
    .i_calibrate (calibrate),
    .o_tick      (rc_tick)
  );

  assign sleep_tick = i_use_xtal ? (i_xtal_32k && !st.xtal_prev)
                                 : rc_tick;
  // The deepest mode stops the counter; it is meaningless there
  assign running = !(i_in_power_mode &&
                     i_power_mode == PM_THREE);
  assign low_power_wake = i_in_power_mode &&
                          i_power_mode != PM_THREE;
  assign clear_wr = i_sfr.we && i_sfr.addr == ADDR_SLEEP_CONTROL &&
                    i_sfr.wdata[CTRL_CLEAR_BIT];

  // After an event the count restarts at one on the next tick, so the
  // compare point recurs after exactly compare << (5*res) ticks
  assign count_step = st.restart ? COUNT_RESTART_VALUE
                                 : st.count + COUNT_RESTART_VALUE;
  assign view_now   = view_slice(st.count, st.res);
  assign cmp_hit    = sleep_tick && running && !clear_wr &&
                      view_slice(count_step, st.res) == st.wake_cmp &&
                      view_now != st.wake_cmp;

  ////////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb
  begin
    next_st = st;
    next_st.xtal_prev = i_xtal_32k;
    next_st.dma  = cmp_hit;
    next_st.wake = cmp_hit && low_power_wake;
    next_st.rdata = READ_ZERO;

    if (clear_wr)
    begin
      next_st.count   = COUNT_CLEAR_VALUE;
      next_st.restart = 1'b0;
    end
    else if (sleep_tick && running)
    begin
      next_st.count   = count_step;
      next_st.restart = cmp_hit;
    end

    if (i_sfr.we)
    begin
      unique case (i_sfr.addr)
        ADDR_SLEEP_CONTROL:
        begin
          next_st.res = i_sfr.wdata[CTRL_RES_LSB +: 2];
          next_st.ctrl_rsvd = i_sfr.wdata[CTRL_RSVD_LSB +: 3];
        end
        ADDR_WAKE_CMP_LOW:  next_st.wake_cmp[7:0]  = i_sfr.wdata;
        ADDR_WAKE_CMP_HIGH: next_st.wake_cmp[15:8] = i_sfr.wdata;
        ADDR_WAKE_IRQ_CONTROL:
        begin
          next_st.ev_mask = i_sfr.wdata[IRQ_MASK_BIT];
          next_st.irq_rsvd_high = i_sfr.wdata[IRQ_RSVD_HIGH_BIT];
          // Zero clears, one leaves the bit alone
          if (!i_sfr.wdata[IRQ_FLAG_BIT])
          begin
            next_st.ev_flag = 1'b0;
          end
          if (!i_sfr.wdata[IRQ_RSVD_LOW_BIT])
          begin
            next_st.irq_rsvd_low = 1'b0;
          end
        end
        default: ;
      endcase
    end

    if (i_cpu_irq_flag_clr)
    begin
      next_st.cpu_flag = 1'b0;
    end
    // Setting comes last so an event beats a clear in the same cycle
    if (cmp_hit)
    begin
      next_st.ev_flag = 1'b1;
      if (st.ev_mask)
      begin
        next_st.cpu_flag = 1'b1;
      end
    end

    if (i_sfr.re)
    begin
      unique case (i_sfr.addr)
        ADDR_WAKE_IRQ_CONTROL:
          next_st.rdata = {2'b00, st.irq_rsvd_high, st.ev_mask, 2'b00,
                           st.irq_rsvd_low, st.ev_flag};
        ADDR_SLEEP_CONTROL:
          next_st.rdata = {1'b0, st.ctrl_rsvd, 1'b0, 1'b0,
                           st.res};
        ADDR_WAKE_CMP_LOW:  next_st.rdata = st.wake_cmp[7:0];
        ADDR_WAKE_CMP_HIGH: next_st.rdata = st.wake_cmp[15:8];
        ADDR_COUNT_LOW:     next_st.rdata = view_now[7:0];
        ADDR_COUNT_HIGH:    next_st.rdata = view_now[15:8];
        default:            next_st.rdata = READ_ZERO;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registers

  always_ff @(posedge i_ref_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      st <= '{count:         COUNT_RESET,
              xtal_prev:     1'b0,
              restart:       1'b0,
              wake_cmp:      {WAKE_CMP_HIGH_RESET, WAKE_CMP_LOW_RESET},
              ctrl_rsvd:     CTRL_RSVD_RESET,
              res:           RES_RESET,
              irq_rsvd_high: 1'b0,
              irq_rsvd_low:  1'b0,
              ev_flag:       1'b0,
              ev_mask:       1'b0,
              cpu_flag:      1'b0,
              dma:           1'b0,
              wake:          1'b0,
              rdata:         READ_ZERO};
    end
    else
    begin
      st <= next_st;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs

  assign o_sfr_hit = (i_sfr.re || i_sfr.we) &&
                     i_sfr.addr >= ADDR_WAKE_IRQ_CONTROL &&
                     i_sfr.addr <= ADDR_COUNT_HIGH;
  assign o_sfr_rdata          = st.rdata;
  assign o_cpu_sleep_irq_flag = st.cpu_flag;
  assign o_sleep_irq_request  = st.cpu_flag && i_sleep_irq_enable &&
                                i_power_mode == PM_ZERO;
  assign o_wake_request       = st.wake;
  assign o_wake_dma_trigger   = st.dma;

  ////////////////////////////////////////////////////////////////////////////
  // Assertions

  sequence s_clear_write;
    clear_wr;
  endsequence

  sequence s_count_at_four;
    st.count == COUNT_CLEAR_VALUE && !st.restart;
  endsequence

  property p_clear_loads_four;
    @(posedge i_ref_clk) disable iff (!i_reset_n)
      s_clear_write |=> s_count_at_four;
  endproperty
  a_clear_loads_four: assert property (p_clear_loads_four)
    else $error("clear write did not load four");

  property p_step_one;
    @(posedge i_ref_clk) disable iff (!i_reset_n)
      (sleep_tick && running && !clear_wr && !st.restart)
      |=> st.count == $past(st.count) + COUNT_RESTART_VALUE;
  endproperty
  a_step_one: assert property (p_step_one)
    else $error("counter did not advance by one on a tick");

  property p_deep_hold;
    @(posedge i_ref_clk) disable iff (!i_reset_n)
      (!running && !clear_wr) |=> $stable(st.count);
  endproperty
  a_deep_hold: assert property (p_deep_hold)
    else $error("counter moved in the deepest mode");

  property p_dma_single;
    @(posedge i_ref_clk) disable iff (!i_reset_n)
      st.dma |=> !st.dma;
  endproperty
  a_dma_single: assert property (p_dma_single)
    else $error("DMA trigger longer than one cycle");

  property p_flag_with_event;
    @(posedge i_ref_clk) disable iff (!i_reset_n)
      st.dma |-> st.ev_flag && (st.cpu_flag || !$past(st.ev_mask));
  endproperty
  a_flag_with_event: assert property (p_flag_with_event)
    else $error("event did not set the flags");

  property p_irq_gate;
    @(posedge i_ref_clk) disable iff (!i_reset_n)
      o_sleep_irq_request |-> i_power_mode == PM_ZERO && st.cpu_flag
                              && i_sleep_irq_enable;
  endproperty
  a_irq_gate: assert property (p_irq_gate)
    else $error("interrupt request not gated");

  property p_wake_needs_event;
    @(posedge i_ref_clk) disable iff (!i_reset_n)
      o_wake_request |-> st.dma && $past(low_power_wake);
  endproperty
  a_wake_needs_event: assert property (p_wake_needs_event)
    else $error("wake without event in a light power mode");

  property p_event_on_match;
    @(posedge i_ref_clk) disable iff (!i_reset_n)
      (st.dma && $stable(st.wake_cmp) && $stable(st.res))
      |-> view_now == st.wake_cmp && st.restart;
  endproperty
  a_event_on_match: assert property (p_event_on_match)
    else $error("event without slice match");

  property p_cmp_write;
    @(posedge i_ref_clk) disable iff (!i_reset_n)
      (i_sfr.we && i_sfr.addr == ADDR_WAKE_CMP_LOW)
      |=> st.wake_cmp[7:0] == $past(i_sfr.wdata);
  endproperty
  a_cmp_write: assert property (p_cmp_write)
    else $error("compare low byte not written");

  property p_view_read;
    @(posedge i_ref_clk) disable iff (!i_reset_n)
      (i_sfr.re && i_sfr.addr == ADDR_COUNT_HIGH)
      |=> o_sfr_rdata == $past(view_now[15:8]);
  endproperty
  a_view_read: assert property (p_view_read)
    else $error("count view high byte mismatch");

  property p_flag_clear;
    @(posedge i_ref_clk) disable iff (!i_reset_n)
      (i_sfr.we && i_sfr.addr == ADDR_WAKE_IRQ_CONTROL &&
       !i_sfr.wdata[IRQ_FLAG_BIT] && !cmp_hit) |=> !st.ev_flag;
  endproperty
  a_flag_clear: assert property (p_flag_clear)
    else $error("flag not cleared by writing zero");

endmodule

// ### sleep_timer_pkg.sv
// Shared constants and carrier types for the sleep wake-up timer.
// Assumes an 8-bit special-function register port and a 25 MHz ref clock.
package sleep_timer_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Register addresses
  localparam logic [7:0] ADDR_WAKE_IRQ_CONTROL = 8'ha1;
  localparam logic [7:0] ADDR_SLEEP_CONTROL    = 8'ha2;
  localparam logic [7:0] ADDR_WAKE_CMP_LOW     = 8'ha3;
  localparam logic [7:0] ADDR_WAKE_CMP_HIGH    = 8'ha4;
  localparam logic [7:0] ADDR_COUNT_LOW        = 8'ha5;
  localparam logic [7:0] ADDR_COUNT_HIGH       = 8'ha6;

  ////////////////////////////////////////////////////////////////////////////
  // Field positions
  localparam int CTRL_RES_LSB      = 0;
  localparam int CTRL_CLEAR_BIT    = 2;
  localparam int CTRL_RSVD_LSB     = 4;
  localparam int IRQ_FLAG_BIT      = 0;
  localparam int IRQ_RSVD_LOW_BIT  = 1;
  localparam int IRQ_MASK_BIT      = 4;
  localparam int IRQ_RSVD_HIGH_BIT = 5;

  ////////////////////////////////////////////////////////////////////////////
  // Reset and load values
  localparam logic [7:0]  WAKE_CMP_LOW_RESET  = 8'h6b;
  localparam logic [7:0]  WAKE_CMP_HIGH_RESET = 8'h87;
  localparam logic [2:0]  CTRL_RSVD_RESET     = 3'h7;
  localparam logic [1:0]  RES_RESET           = 2'h0;
  localparam logic [30:0] COUNT_RESET         = 31'h0;
  localparam logic [30:0] COUNT_CLEAR_VALUE   = 31'h4;
  localparam logic [30:0] COUNT_RESTART_VALUE = 31'h1;
  localparam logic [7:0]  READ_ZERO           = 8'h00;

  ////////////////////////////////////////////////////////////////////////////
  // Timing
  localparam int          RES_STEP        = 5;
  localparam int          COUNT_W         = 31;
  localparam int          RC_DIV_W        = 10;
  localparam logic [9:0]  RC_DIV_PERIOD   = 10'h2ee;
  // Uncalibrated RC period before the first calibration; value is arbitrary
  localparam logic [9:0]  RC_UNCAL_PERIOD = 10'h2bc;
  localparam logic [9:0]  RC_DIV_ONE      = 10'h001;
  localparam logic [9:0]  RC_DIV_ZERO     = 10'h000;

  ////////////////////////////////////////////////////////////////////////////
  // Types
  typedef enum logic [1:0]
  {
    PM_ZERO  = 2'h0,
    PM_ONE   = 2'h1,
    PM_TWO   = 2'h2,
    PM_THREE = 2'h3
  } power_mode_t;

  typedef struct packed
  {
    logic       we;
    logic       re;
    logic [7:0] addr;
    logic [7:0] wdata;
  } sfr_req_t;

endpackage

// ### rc_tick_divider.sv
// Low-power RC oscillator model: divides the reference clock into ticks.
// Assumes the reference clock runs at the synthesizer reference rate.
`timescale 1ns/1ps
module rc_tick_divider
  import sleep_timer_pkg::*;
(
  // Clock and reset
  input  wire logic i_ref_clk,
  input  wire logic i_reset_n,
  // Control
  input  wire logic i_calibrate,
  // Tick out
  output logic      o_tick
);

  typedef struct packed
  {
    logic [9:0] period;
    logic [9:0] cnt;
    logic       tick;
  } div_state_t;

  div_state_t st;
  div_state_t next_st;

  always_comb
  begin
    next_st = st;
    // Calibration locks the period; outside it the last result is kept
    if (i_calibrate)
    begin
      next_st.period = RC_DIV_PERIOD;
    end
    next_st.tick = (st.cnt == RC_DIV_ZERO);
    if (st.cnt == RC_DIV_ZERO)
    begin
      next_st.cnt = st.period - RC_DIV_ONE;
    end
    else
    begin
      next_st.cnt = st.cnt - RC_DIV_ONE;
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      st <= '{period: RC_UNCAL_PERIOD, cnt: RC_DIV_ZERO, tick: 1'b0};
    end
    else
    begin
      st <= next_st;
    end
  end

  assign o_tick = st.tick;

  ////////////////////////////////////////////////////////////////////////////
  // Assertions

  // Outside calibration the last result must be kept, not drift back
  property p_period_hold;
    @(posedge i_ref_clk) disable iff (!i_reset_n)
      !i_calibrate |=> $stable(st.period);
  endproperty
  a_period_hold: assert property (p_period_hold)
    else $error("RC period changed without calibration");

endmodule

// ### sleep_wakeup_timer_tb_top.sv
// Self-checking bench for the sleep wake-up timer, driven at falling edges.
// Assumes the design package and the design files are compiled beforehand.
`timescale 1ns/1ps
module sleep_wakeup_timer_tb_top
  import sleep_timer_pkg::*;
  ;
  localparam int LIMIT = 20000;

  logic        i_ref_clk;
  logic        i_reset_n;
  sfr_req_t    sfr;
  logic        o_sfr_hit;
  logic [7:0]  o_sfr_rdata;
  logic        xtal;
  logic        use_xtal;
  logic        hs_on;
  logic        in_pm;
  power_mode_t pmode;
  logic        irq_en;
  logic        flag_clr;
  logic        cpu_flag;
  logic        irq_req;
  logic        wake;
  logic        dma;
  logic        dma_d = 1'b0;
  int          error_cnt;
  int          total_checks;
  int          cycles = 0;
  int          dma_cnt = 0;
  int          wake_cnt = 0;

  sleep_wakeup_timer sleep_wakeup_timer_inst (
    .i_ref_clk            (i_ref_clk),
    .i_reset_n            (i_reset_n),
    .i_sfr                (sfr),
    .o_sfr_hit            (o_sfr_hit),
    .o_sfr_rdata          (o_sfr_rdata),
    .i_xtal_32k           (xtal),
    .i_use_xtal           (use_xtal),
    .i_hs_xosc_on         (hs_on),
    .i_in_power_mode      (in_pm),
    .i_power_mode         (pmode),
    .i_sleep_irq_enable   (irq_en),
    .i_cpu_irq_flag_clr   (flag_clr),
    .o_cpu_sleep_irq_flag (cpu_flag),
    .o_sleep_irq_request  (irq_req),
    .o_wake_request       (wake),
    .o_wake_dma_trigger   (dma)
  );

  always #20 i_ref_clk = ~i_ref_clk;

  ////////////////////////////////////////////////////////////////////////////
  // Shared tasks
  task automatic results();
    $display("checks %0d mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task automatic chk(input string name, input logic [15:0] exp,
                     input logic [15:0] got);
    total_checks++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge i_ref_clk);
    sfr.we    = 1'b1;
    sfr.addr  = a;
    sfr.wdata = d;
    @(negedge i_ref_clk);
    sfr.we = 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    @(negedge i_ref_clk);
    sfr.re   = 1'b1;
    sfr.addr = a;
    #1;
    chk("hit", 16'(a >= 8'ha1 && a <= 8'ha6), 16'(o_sfr_hit));
    @(negedge i_ref_clk);
    sfr.re = 1'b0;
    v      = o_sfr_rdata;
  endtask

  task automatic rdc(input logic [7:0] a, input logic [7:0] e,
                     input string name);
    logic [7:0] v;
    rd(a, v);
    chk(name, 16'(e), 16'(v));
  endtask

  // Crystal held long enough per phase for the input sampler to see it
  task automatic tick(input int n);
    repeat (n)
    begin
      @(negedge i_ref_clk);
      xtal = 1'b1;
      repeat (4) @(negedge i_ref_clk);
      xtal = 1'b0;
      repeat (4) @(negedge i_ref_clk);
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Scenarios
  task automatic t_reset_values();
    rdc(ADDR_WAKE_IRQ_CONTROL, 8'h00, "irq ctrl");
    rdc(ADDR_SLEEP_CONTROL, 8'h70, "ctrl");
    rdc(ADDR_WAKE_CMP_LOW, 8'h6b, "cmp low");
    rdc(ADDR_WAKE_CMP_HIGH, 8'h87, "cmp high");
    rdc(ADDR_COUNT_LOW, 8'h00, "count low");
    rdc(ADDR_COUNT_HIGH, 8'h00, "count high");
    wr(ADDR_COUNT_LOW, 8'hff);
    rdc(ADDR_COUNT_LOW, 8'h00, "count low ro");
    wr(8'hb0, 8'h55);
    rdc(8'hb0, 8'h00, "unmapped");
    $display("test reset_values done");
  endtask

  task automatic t_event();
    int d;
    int w;
    wr(ADDR_SLEEP_CONTROL, 8'h04);
    rdc(ADDR_SLEEP_CONTROL, 8'h00, "ctrl clear");
    rdc(ADDR_COUNT_LOW, 8'h04, "count cleared");
    tick(2);
    rdc(ADDR_COUNT_LOW, 8'h06, "count step");
    wr(ADDR_WAKE_CMP_HIGH, 8'h01);
    wr(ADDR_WAKE_CMP_LOW, 8'h8b);
    rdc(ADDR_WAKE_CMP_LOW, 8'h8b, "cmp low rw");
    rdc(ADDR_WAKE_CMP_HIGH, 8'h01, "cmp high rw");
    wr(ADDR_WAKE_IRQ_CONTROL, 8'h10);
    d = dma_cnt;
    w = wake_cnt;
    // Sleep entry rides a crystal rising edge; the event is 388 ticks on
    @(negedge i_ref_clk);
    xtal  = 1'b1;
    in_pm = 1'b1;
    pmode = PM_TWO;
    repeat (4) @(negedge i_ref_clk);
    xtal = 1'b0;
    repeat (4) @(negedge i_ref_clk);
    tick(387);
    chk("early dma", 16'h0, 16'(dma_cnt - d));
    tick(1);
    chk("dma pulses", 16'h1, 16'(dma_cnt - d));
    chk("wake pulses", 16'h1, 16'(wake_cnt - w));
    rdc(ADDR_WAKE_IRQ_CONTROL, 8'h11, "flag set");
    chk("cpu flag", 16'h1, 16'(cpu_flag));
    chk("irq in mode two", 16'h0, 16'(irq_req));
    $display("test event done");
  endtask

  task automatic t_period_irq();
    int d;
    int w;
    @(negedge i_ref_clk);
    in_pm = 1'b0;
    pmode = PM_ZERO;
    #1;
    chk("irq active", 16'h1, 16'(irq_req));
    @(negedge i_ref_clk);
    irq_en = 1'b0;
    #1;
    chk("irq disabled", 16'h0, 16'(irq_req));
    @(negedge i_ref_clk);
    irq_en = 1'b1;
    // Compare drops below the count, so the counter is cleared first
    wr(ADDR_SLEEP_CONTROL, 8'h04);
    tick(2);
    wr(ADDR_WAKE_CMP_HIGH, 8'h00);
    wr(ADDR_WAKE_CMP_LOW, 8'h09);
    tick(3);
    d = dma_cnt;
    w = wake_cnt;
    tick(8);
    chk("no dma yet", 16'h0, 16'(dma_cnt - d));
    rdc(ADDR_COUNT_LOW, 8'h08, "count restart");
    tick(1);
    chk("period dma", 16'h1, 16'(dma_cnt - d));
    chk("no wake active", 16'h0, 16'(wake_cnt - w));
    wr(ADDR_WAKE_IRQ_CONTROL, 8'h11);
    rdc(ADDR_WAKE_IRQ_CONTROL, 8'h11, "flag w1");
    wr(ADDR_WAKE_IRQ_CONTROL, 8'h10);
    rdc(ADDR_WAKE_IRQ_CONTROL, 8'h10, "flag w0");
    @(negedge i_ref_clk);
    flag_clr = 1'b1;
    @(negedge i_ref_clk);
    flag_clr = 1'b0;
    chk("cpu flag clr", 16'h0, 16'(cpu_flag));
    chk("irq clr", 16'h0, 16'(irq_req));
    $display("test period_irq done");
  endtask

  task automatic t_mask_pm3();
    int d;
    wr(ADDR_WAKE_IRQ_CONTROL, 8'h00);
    d = dma_cnt;
    tick(9);
    chk("dma masked", 16'h1, 16'(dma_cnt - d));
    chk("cpu flag masked", 16'h0, 16'(cpu_flag));
    rdc(ADDR_WAKE_IRQ_CONTROL, 8'h01, "flag masked");
    @(negedge i_ref_clk);
    in_pm = 1'b1;
    pmode = PM_THREE;
    rdc(ADDR_COUNT_LOW, 8'h09, "count before deep");
    tick(3);
    rdc(ADDR_COUNT_LOW, 8'h09, "count deep");
    @(negedge i_ref_clk);
    pmode = PM_ONE;
    // First tick restarts at one after the event, the second steps on
    tick(2);
    rdc(ADDR_COUNT_LOW, 8'h02, "count mode one");
    $display("test mask_pm3 done");
  endtask

  // Compare moved out of reach first so no restart disturbs the count
  task automatic t_resolution();
    wr(ADDR_WAKE_CMP_LOW, 8'hff);
    wr(ADDR_SLEEP_CONTROL, 8'h04);
    tick(28);
    for (int r = 0; r < 4; r++)
    begin
      wr(ADDR_SLEEP_CONTROL, 8'(r));
      rdc(ADDR_SLEEP_CONTROL, 8'(r), "res");
      rdc(ADDR_COUNT_LOW, 8'(32 >> (RES_STEP * r)), "slice");
      rdc(ADDR_COUNT_HIGH, 8'h00, "slice high");
    end
    $display("test resolution done");
  endtask

  // Two or three RC ticks fit in 1600 cycles whatever the divider phase
  task automatic t_rc();
    logic [7:0] v;
    @(negedge i_ref_clk);
    use_xtal = 1'b0;
    in_pm    = 1'b0;
    pmode    = PM_ZERO;
    wr(ADDR_SLEEP_CONTROL, 8'h04);
    repeat (800) @(negedge i_ref_clk);
    // Calibration stops; the held period keeps the tick rate
    hs_on = 1'b0;
    repeat (800) @(negedge i_ref_clk);
    rd(ADDR_COUNT_LOW, v);
    chk("rc ticks", 16'h1, 16'(v >= 8'h06 && v <= 8'h07));
    $display("test rc done");
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Monitor and timeout
  always @(posedge i_ref_clk)
  begin
    cycles++;
    if (dma === 1'b1)
      dma_cnt++;
    if (wake === 1'b1)
      wake_cnt++;
    if (dma === 1'b1 && dma_d === 1'b1)
    begin
      error_cnt++;
      $display("wrong value dma width expected 1 seen 2");
    end
    dma_d <= dma;
    if (cycles > LIMIT)
    begin
      error_cnt++;
      results();
    end
  end

  initial
  begin
    i_ref_clk    = 1'b0;
    i_reset_n    = 1'b0;
    sfr          = '0;
    xtal         = 1'b0;
    use_xtal     = 1'b1;
    hs_on        = 1'b1;
    in_pm        = 1'b0;
    pmode        = PM_ZERO;
    irq_en       = 1'b1;
    flag_clr     = 1'b0;
    error_cnt    = 0;
    total_checks = 0;
    repeat (5) @(negedge i_ref_clk);
    i_reset_n = 1'b1;
    t_reset_values();
    t_event();
    t_period_irq();
    t_mask_pm3();
    t_resolution();
    t_rc();
    results();
  end
endmodule
